// file: inc/fp_consts.svh
// constants for the front panel scan and refresh block
// Operation
// - row strobes step through eight rows, each set by a key-area access
// - a column reading low in the selected row is a pressed key
// - one new key press per row scan, the lowest column, is sent as an ASCII code on serial out
// - received digits and minus signs become dot patterns on the display
// - areas get unique enables decoded from A3, A6, A7, A14, A15
// - address bits 0 to 13 go to every area in common
// - forty character-pair positions of 5 by 7 dots
// - one-hot 40-bit grid register, one pair enabled in turn near 80 Hz
// - seven shared 10-bit anode shift registers hold active pair dots
// - each anode register serves one dot row across the active pair
// - ten column shift pulses load the next pair, outputs unchanged
// - after the tenth pulse blanking turns off the current grid
// - while blanked one latch pulse updates anodes and steps the grid
// - blanking is released after the latch pulse
// - a 16-bit timer paces each refresh step
// - refresh gating and grid data leave through the parallel port
// - clear-to-send is bit 7 of the parallel port
// - key and display logic sit in the address map as locations
`ifndef FP_CONSTS_SVH
`define FP_CONSTS_SVH
`define FP_CLK_NS 50
`define FP_STEP_NS 312500
`define FP_BIT_NS 104000
`define FP_DWELL_NS 100000
`define FP_PAIRS 40
`define FP_ROWS 7
`define FP_COLS 10
`define FP_CHAR_COLS 5
`define FP_CHARS 80
`define FP_KEY_ROWS 8
`define FP_A15 15
`define FP_A14 14
`define FP_A7 7
`define FP_A6 6
`define FP_A3 3
`define FP_LOC_MSB 13
`define FP_KEY_BASE 16'h00c0
`define FP_KEY_CODE_BASE 8'h40
`define FP_CTRL_CHAR 8'h20
`define FP_GRID_RESET 40'h00_0000_0001
`define FP_ROW_RESET 8'hfe
`endif

// file: inc/fp_pkg.sv
// types for the front panel scan and refresh block
package fp_pkg;
  typedef enum logic [2:0] {
    FP_WAIT = 3'h0,
    FP_SHIFT = 3'h1,
    FP_BLANK = 3'h3,
    FP_LATCH = 3'h2,
    FP_OPEN = 3'h6
  } fp_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
  } fp_bus_t;
  typedef struct packed {
    logic cts;
    logic [2:0] spare;
    logic grid_data;
    logic blank_n;
    logic latch;
    logic shift;
  } fp_port_t;
  typedef struct packed {
    logic rom;
    logic ram;
    logic ctrl;
    logic key;
    logic disp;
  } fp_area_t;
endpackage : fp_pkg

// file: rtl/fp_panel.sv
// front panel key scan, serial link and display refresh
`timescale 1ns/1ps
`include "fp_consts.svh"
module fp_panel
  import fp_pkg::*;
#(
  parameter logic [15:0] STEP_CYCLES = 16'(`FP_STEP_NS / `FP_CLK_NS)
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire fp_bus_t bus,
  input wire logic [7:0] key_col_n,
  input wire logic rxd,
  output fp_area_t area_en,
  output logic [13:0] loc_addr,
  output logic [7:0] key_row_n,
  output logic txd,
  output fp_port_t port,
  output logic [39:0] grid,
  output logic [69:0] anode
);
  localparam int BIT_CYC = `FP_BIT_NS / `FP_CLK_NS;
  localparam int DWELL_CYC = `FP_DWELL_NS / `FP_CLK_NS;

  function automatic logic [34:0] fp_glyph(input logic [7:0] ch);
    case (ch)
      8'h30: fp_glyph = {7'h3e, 7'h51, 7'h49, 7'h45, 7'h3e};
      8'h31: fp_glyph = {7'h00, 7'h42, 7'h7f, 7'h40, 7'h00};
      8'h32: fp_glyph = {7'h42, 7'h61, 7'h51, 7'h49, 7'h46};
      8'h33: fp_glyph = {7'h21, 7'h41, 7'h45, 7'h4b, 7'h31};
      8'h34: fp_glyph = {7'h18, 7'h14, 7'h12, 7'h7f, 7'h10};
      8'h35: fp_glyph = {7'h27, 7'h45, 7'h45, 7'h45, 7'h39};
      8'h36: fp_glyph = {7'h3c, 7'h4a, 7'h49, 7'h49, 7'h30};
      8'h37: fp_glyph = {7'h01, 7'h71, 7'h09, 7'h05, 7'h03};
      8'h38: fp_glyph = {7'h36, 7'h49, 7'h49, 7'h49, 7'h36};
      8'h39: fp_glyph = {7'h06, 7'h49, 7'h49, 7'h29, 7'h1e};
      8'h2d: fp_glyph = {7'h08, 7'h08, 7'h08, 7'h08, 7'h08};
      default: fp_glyph = 35'h0_0000_0000;
    endcase
  endfunction : fp_glyph

  fp_state_t state;
  logic [15:0] timer, dec_addr, dwell;
  logic tick, phase, dec_act, send, tx_busy, rx_busy;
  logic [3:0] col_cnt, tx_left, rx_bits;
  logic [5:0] grid_idx, nxt_idx, col_base;
  logic [39:0] grid_sr;
  logic [9:0] anode_sr [`FP_ROWS];
  logic [7:0] text [`FP_CHARS];
  logic [6:0] cursor, char_idx, col_bits;
  logic [34:0] glyph;
  logic [2:0] scan_row, hit_col;
  logic [7:0] prev_n [`FP_KEY_ROWS];
  logic [7:0] hit;
  logic [9:0] tx_sr;
  logic [11:0] tx_cnt, rx_cnt;
  logic [8:0] rx_sr;
  default clocking fp_cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // 16-bit refresh pacing timer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timer <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (timer == 16'h0000);
      timer <= (timer == 16'h0000) ? STEP_CYCLES - 16'h0001 :
               timer - 16'h0001;
    end
  end
  assign nxt_idx = (grid_idx == 6'(`FP_PAIRS - 1)) ? 6'h00 :
                   grid_idx + 6'h01;
  // first five shifts carry the left char, next five the right one
  assign char_idx = {nxt_idx, 1'b0} + 7'(col_cnt >= 4'(`FP_CHAR_COLS));
  assign glyph = fp_glyph(text[char_idx]);
  assign col_base = (col_cnt >= 4'(`FP_CHAR_COLS)) ?
                    6'(34 - 7 * (col_cnt - 4'(`FP_CHAR_COLS))) :
                    6'(34 - 7 * col_cnt);
  assign col_bits = glyph[col_base -: 7];
  // refresh sequencer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= FP_WAIT;
      phase <= 1'b0;
      col_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        FP_WAIT:
        begin
          if (tick)
          begin
            state <= FP_SHIFT;
            col_cnt <= 4'h0;
            phase <= 1'b0;
          end
        end
        FP_SHIFT:
        begin
          phase <= ~phase;
          if (phase)
          begin
            col_cnt <= col_cnt + 4'h1;
            if (col_cnt == 4'(`FP_COLS - 1))
              state <= FP_BLANK;
          end
        end
        FP_BLANK: state <= FP_LATCH;
        FP_LATCH: state <= FP_OPEN;
        FP_OPEN: state <= FP_WAIT;
        default: state <= FP_WAIT;
      endcase
    end
  end
  // anode shift registers, one per dot row of the pair
  genvar r;
  generate
    for (r = 0; r < `FP_ROWS; r++)
    begin : g_anode
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          anode_sr[r] <= 10'h000;
          anode[r*`FP_COLS +: `FP_COLS] <= 10'h000;
        end
        else
        begin
          if (state == FP_SHIFT && phase)
            anode_sr[r] <= {anode_sr[r][8:0], col_bits[r]};
          if (state == FP_LATCH)
            anode[r*`FP_COLS +: `FP_COLS] <= anode_sr[r];
        end
      end
    end
  endgenerate
  // grid select and port outputs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      grid_sr <= `FP_GRID_RESET;
      grid_idx <= 6'h00;
      grid <= 40'h00_0000_0000;
      port <= '0;
    end
    else
    begin
      if (state == FP_LATCH)
      begin
        grid_sr <= {grid_sr[38:0], grid_sr[39]};
        grid_idx <= nxt_idx;
      end
      grid <= (state == FP_BLANK || state == FP_LATCH) ?
              40'h00_0000_0000 : grid_sr;
      port.shift <= (state == FP_SHIFT) && !phase;
      port.latch <= (state == FP_LATCH);
      port.blank_n <= !(state == FP_BLANK || state == FP_LATCH);
      port.grid_data <= grid_sr[39];
      port.spare <= 3'h0;
      port.cts <= !tx_busy;
    end
  end
  // block decode; the panel's own row accesses go through it too
  assign dec_act = bus.rd | bus.wr;
  assign dec_addr = dec_act ? bus.addr : (`FP_KEY_BASE | 16'(scan_row));
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      area_en <= '0;
      loc_addr <= 14'h0000;
      key_row_n <= `FP_ROW_RESET;
    end
    else
    begin
      area_en.rom <= dec_addr[`FP_A15];
      area_en.ram <= !dec_addr[`FP_A15] && dec_addr[`FP_A14];
      area_en.ctrl <= !dec_addr[`FP_A15] && !dec_addr[`FP_A14] &&
                      dec_addr[`FP_A7] && !dec_addr[`FP_A6];
      area_en.key <= !dec_addr[`FP_A15] && !dec_addr[`FP_A14] &&
                     dec_addr[`FP_A7] && dec_addr[`FP_A6] &&
                     !dec_addr[`FP_A3];
      area_en.disp <= !dec_addr[`FP_A15] && !dec_addr[`FP_A14] &&
                      dec_addr[`FP_A7] && dec_addr[`FP_A6] &&
                      dec_addr[`FP_A3];
      loc_addr <= dec_addr[`FP_LOC_MSB:0];
      if (!dec_addr[`FP_A15] && !dec_addr[`FP_A14] && dec_addr[`FP_A7] &&
          dec_addr[`FP_A6] && !dec_addr[`FP_A3])
        key_row_n <= ~(8'h01 << dec_addr[2:0]);
    end
  end
  // newly pressed keys of the strobed row, lowest column first
  assign hit = ~key_col_n & prev_n[scan_row];
  always_comb
  begin
    hit_col = 3'h0;
    for (int c = 7; c >= 0; c--)
      if (hit[c])
        hit_col = 3'(c);
  end
  assign send = (dwell == 16'(DWELL_CYC - 1)) && (hit != 8'h00) && !tx_busy;
  // row scan; waits on a busy transmitter while the row shows a new press
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dwell <= 16'h0000;
      scan_row <= 3'h0;
      for (int i = 0; i < `FP_KEY_ROWS; i++)
        prev_n[i] <= 8'hff;
    end
    else if (dwell != 16'(DWELL_CYC - 1))
      dwell <= dwell + 16'h0001;
    else if (!tx_busy || hit == 8'h00)
    begin
      dwell <= 16'h0000;
      prev_n[scan_row] <= key_col_n;
      scan_row <= scan_row + 3'h1;
    end
  end
  // serial transmit, 8N1
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_sr <= 10'h3ff;
      tx_left <= 4'h0;
      tx_cnt <= 12'h000;
      tx_busy <= 1'b0;
      txd <= 1'b1;
    end
    else if (send)
    begin
      tx_sr <= {1'b1, `FP_KEY_CODE_BASE | {2'b00, scan_row, hit_col},
                1'b0};
      tx_left <= 4'(`FP_COLS);
      tx_cnt <= 12'h000;
      tx_busy <= 1'b1;
      txd <= 1'b1;
    end
    else if (tx_busy)
    begin
      txd <= tx_sr[0];
      if (tx_cnt == 12'(BIT_CYC - 1))
      begin
        tx_cnt <= 12'h000;
        tx_sr <= {1'b1, tx_sr[9:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1)
          tx_busy <= 1'b0;
      end
      else
        tx_cnt <= tx_cnt + 12'h001;
    end
    else
      txd <= 1'b1;
  end
  // serial receive into the character buffer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_busy <= 1'b0;
      rx_cnt <= 12'h000;
      rx_bits <= 4'h0;
      rx_sr <= 9'h000;
      cursor <= 7'h00;
      for (int i = 0; i < `FP_CHARS; i++)
        text[i] <= `FP_CTRL_CHAR;
    end
    else if (!rx_busy)
    begin
      if (!rxd)
      begin
        rx_busy <= 1'b1;
        rx_cnt <= 12'(BIT_CYC / 2);
        rx_bits <= 4'h0;
      end
    end
    else if (rx_cnt == 12'(BIT_CYC - 1))
    begin
      rx_cnt <= 12'h000;
      rx_sr <= {rxd, rx_sr[8:1]};
      rx_bits <= rx_bits + 4'h1;
      if (rx_bits == 4'h9)
      begin
        rx_busy <= 1'b0;
        // control codes home the cursor
        if (rx_sr[8:1] < `FP_CTRL_CHAR)
          cursor <= 7'h00;
        else
        begin
          text[cursor] <= rx_sr[8:1];
          cursor <= (cursor == 7'(`FP_CHARS - 1)) ? 7'h00 :
                    cursor + 7'h01;
        end
      end
    end
    else
      rx_cnt <= rx_cnt + 12'h001;
  end
  a_grid_onehot: assert property ($onehot(grid_sr))
    else $error("grid select not one-hot");
  a_ten_shifts: assert property ((state == FP_BLANK) |->
    col_cnt == 4'(`FP_COLS)) else $error("blank before ten shifts");
  a_shift_blanked: assert property (state == FP_SHIFT && phase &&
    col_cnt == 4'(`FP_COLS - 1) |=> ##1 !port.blank_n)
    else $error("no blank after tenth shift");
  a_latch_blank: assert property (port.latch |->
    !port.blank_n && grid == 40'h00_0000_0000)
    else $error("latch while not blanked");
  a_grid_step: assert property ((state == FP_LATCH) |=>
    {grid_sr[0], grid_sr[39:1]} == $past(grid_sr))
    else $error("grid did not advance");
  a_unblank_late: assert property ((state == FP_LATCH) |->
    ##2 port.blank_n && !port.latch) else $error("blank not released");
  a_timer_pace: assert property (state == FP_WAIT && tick |=>
    state == FP_SHIFT) else $error("refresh step missed");
  a_row_onehot: assert property ($onehot(~key_row_n))
    else $error("row strobe not one-hot");
  a_tx_start: assert property (send |=> ##1 !txd)
    else $error("start bit missing");
  // first edge after release still shows reset outputs
  a_cts_port: assert property ($past(arst_n) |->
    port.cts == !$past(tx_busy)) else $error("clear-to-send wrong");
  a_area_unique: assert property ($onehot0(area_en))
    else $error("area enables overlap");
endmodule : fp_panel

// file: tb/fp_host_model.sv
// main processor end of the serial link
`timescale 1ns/1ps
module fp_host_model #(
  parameter int BIT_CYCLES = 2080
)(
  input wire logic clk,
  input wire logic txd,
  output logic rxd = 1'b1,
  output logic [7:0] rx_byte,
  output int rx_count
);
  int i;
  // 8n1, lsb first; line rests high after the stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clk);
      rxd <= frame[k];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask : send_byte
  // mid-bit sampling keeps clear of edge jitter
  initial
  begin
    rx_byte = 8'h00;
    rx_count = 0;
    forever
    begin
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(posedge clk);
        rx_byte[i] <= txd;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      rx_count <= rx_count + 1;
    end
  end
endmodule : fp_host_model

// file: tb/tb_top.sv
// self-checking bench for the front panel block
`timescale 1ns/1ps
module tb_top
  import fp_pkg::*;
;
  localparam int STEP = 40;
  logic clk, arst_n, rxd, txd, press;
  fp_bus_t bus;
  logic [7:0] key_col_n, key_row_n, rx_byte;
  fp_area_t area_en;
  logic [13:0] loc_addr;
  fp_port_t port;
  logic [39:0] grid;
  logic [69:0] anode;
  int rx_count, n_errors, n_tests;

  fp_panel #(.STEP_CYCLES(16'(STEP))) dut (.clk(clk), .arst_n(arst_n),
    .bus(bus), .key_col_n(key_col_n), .rxd(rxd), .area_en(area_en),
    .loc_addr(loc_addr), .key_row_n(key_row_n), .txd(txd), .port(port),
    .grid(grid), .anode(anode));
  fp_host_model host (.clk(clk), .txd(txd), .rxd(rxd), .rx_byte(rx_byte),
    .rx_count(rx_count));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // one key at row 3, column 2
  always @(posedge clk) key_col_n <= (press && !key_row_n[3]) ? 8'hfb : 8'hff;

  task check(input string name, input logic [69:0] seen,
             input logic [69:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task report_and_stop;
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task tick;
    @(posedge clk);
    #1;
  endtask : tick

  task access(input logic [15:0] a, input logic w);
    @(posedge clk);
    bus <= '{addr: a, rd: ~w, wr: w};
    @(posedge clk);
    bus <= '{addr: a, rd: 1'b0, wr: 1'b0};
    #1;
  endtask : access

  task test_decode;
    logic [15:0] adr [6];
    logic [4:0] exp [6];
    adr = '{16'h8000, 16'h4abc, 16'h0080, 16'h00c5, 16'h3fff, 16'h0040};
    exp = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
    for (int k = 0; k < 6; k++)
    begin
      access(adr[k], k[0]);
      check("area_en", area_en, exp[k]);
      check("loc_addr", loc_addr, adr[k][13:0]);
    end
    for (int r = 0; r < 8; r++)
    begin
      access(16'h00c0 | 16'(r), 1'b0);
      check("row_strobe", key_row_n, 8'(~(8'h01 << r)));
      check("key_area", area_en, 5'h02);
    end
  endtask : test_decode

  task test_refresh;
    logic [39:0] exp;
    logic [69:0] held;
    int shifts, gap, seen;
    seen = 0;
    shifts = 0;
    gap = 0;
    held = anode;
    exp = '0;
    for (int c = 0; c < 45 * STEP && seen < 42; c++)
    begin
      tick;
      gap++;
      if (port.latch === 1'b1)
      begin
        check("blank_n", port.blank_n, 1'b0);
        check("grid_blank", grid, 40'h0);
        if (seen > 0)
        begin
          check("shifts", shifts, 10);
          check("step_gap", gap, STEP);
        end
        tick;
        check("blank_rel", port.blank_n, 1'b1);
        if (seen > 0)
          check("grid", grid, exp);
        check("grid_data", port.grid_data, grid[39]);
        exp = {grid[38:0], grid[39]};
        held = anode;
        shifts = 0;
        gap = 1;
        seen++;
      end
      else
      begin
        if (port.shift === 1'b1)
          shifts++;
        check("anode_hold", anode, held);
      end
    end
    check("steps", seen, 42);
  endtask : test_refresh

  task test_key;
    int c;
    @(posedge clk);
    press <= 1'b1;
    for (c = 0; c < 40000 && txd !== 1'b0; c++)
      tick;
    repeat (10) tick;
    check("cts_busy", port.cts, 1'b0);
    for (c = 0; c < 25000 && rx_count == 0; c++)
      tick;
    check("key_code", rx_byte, 8'h5a);
    @(posedge clk);
    press <= 1'b0;
  endtask : test_key

  task test_display;
    int lit, dark;
    lit = 0;
    dark = 0;
    host.send_byte(8'h38);
    repeat (2 * STEP) tick;
    for (int c = 0; c < 45 * STEP && (lit == 0 || dark == 0); c++)
    begin
      tick;
      if (grid === 40'h1 && lit == 0)
      begin
        lit = 1;
        check("anode_lit", |anode, 1'b1);
        check("anode_right", anode & {7{10'h01f}}, 70'h0);
      end
      if (grid === 40'h2 && dark == 0)
      begin
        dark = 1;
        check("anode_dark", anode, 70'h0);
      end
    end
    check("pairs_seen", lit + dark, 2);
  endtask : test_display

  // worst case is about 89.6k cycles
  initial
  begin
    #4500000;
    n_errors++;
    report_and_stop;
  end

  initial
  begin
    n_errors = 0;
    n_tests = 0;
    arst_n = 1'b0;
    press = 1'b0;
    bus = '0;
    repeat (5) @(posedge clk);
    #1;
    check("rst_grid", grid, 40'h0);
    check("rst_port", port, 8'h00);
    check("rst_rows", key_row_n, 8'hfe);
    check("rst_txd", txd, 1'b1);
    @(posedge clk);
    arst_n <= 1'b1;
    tick;
    check("rel_area", area_en, 5'h02);
    check("rel_cts", port.cts, 1'b1);
    check("rel_grid", grid, 40'h1);
    test_decode;
    test_refresh;
    test_key;
    test_display;
    report_and_stop;
  end
endmodule : tb_top
